// ### logic/lrcr_bank.sv
// Purpose: holding register bank for remote lift commands
// Assumes: word-addressed register port, read data one cycle after strobe
// Notes: call, door, block, date, time and light writes pulse a one-cycle strobe; mode flags and unlock give levels
// ==========================================
`timescale 1ns/1ns
`include "lrcr_defs.svh"
module lrcr_bank
#(
	parameter longint RELOCK_CYCLES = `LRCR_RELOCK_CYC
)
(
	input wire logic clk_sys,
	input wire logic rst_b,
	input wire logic [15:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic doors_closed,
	input wire logic nobody_trapped,
	output logic [15:0] reg_rdata,
	output logic call_valid,
	output logic [7:0] call_floor,
	output logic [3:0] call_doors,
	output lrcr_pkg::lrcr_ctype_t call_type,
	output logic call_is_car,
	output logic [3:0] door_open_press,
	output logic [3:0] door_close_press,
	output logic block_valid,
	output logic [7:0] block_floor,
	output logic [3:0] block_doors,
	output logic block_car_calls,
	output logic block_disable,
	output logic clock_set,
	output logic [7:0] date_month,
	output logic [7:0] date_day,
	output logic [7:0] time_hour,
	output logic [7:0] time_minute,
	output logic clock_unlocked,
	output logic standby_on,
	output logic hall_disabled,
	output logic doors_hold,
	output logic service_on,
	output logic light_auto,
	output logic light_on_pulse,
	output logic light_off_pulse
);
	import lrcr_pkg::*;

	// unlock window counter sized for the whole relock span, ten minutes needs 36 bits
	localparam int CNT_W = (RELOCK_CYCLES > 64'd1) ? $clog2(RELOCK_CYCLES) : 1;
	localparam logic [CNT_W-1:0] RELOCK_LAST = CNT_W'(RELOCK_CYCLES - 64'd1);

	typedef struct packed
	{
		logic [15:0] rdata;
		logic [15:0] call;
		logic call_v;
		logic [3:0] dopen;
		logic [3:0] dclose;
		logic [15:0] door;
		logic [15:0] blk;
		logic blk_v;
		logic [15:0] date;
		logic [15:0] tim;
		logic clk_set;
		lrcr_lock_t lock;
		logic [CNT_W-1:0] cnt;
		logic standby;
		logic hall;
		logic hold;
		logic service;
		logic [15:0] light;
		logic lon;
		logic loff;
		logic car;
		logic lauto;
		logic unl;
	} lrcr_state_t;

	lrcr_state_t s_q;
	lrcr_state_t s_d;

	localparam lrcr_state_t S_RST = '{lock: LRCR_LOCKED, lauto: 1'b1, default: '0};

	// ==========================================
	// next state
	always_comb
	begin
		logic wr_call;
		logic wr_unl;
		logic wr_date;
		logic wr_time;
		logic wr_door;
		logic wr_blk;
		logic [3:0] ct;
		logic [3:0] didx;
		wr_call = reg_wr && reg_addr == `LRCR_OFS_CALL;
		wr_unl = reg_wr && reg_addr == `LRCR_OFS_UNLOCK;
		wr_date = reg_wr && reg_addr == `LRCR_OFS_DATE;
		wr_time = reg_wr && reg_addr == `LRCR_OFS_TIME;
		wr_door = reg_wr && reg_addr == `LRCR_OFS_DOOR;
		wr_blk = reg_wr && reg_addr == `LRCR_OFS_BLOCK;
		ct = reg_wdata[`LRCR_CTYPE_MSB:`LRCR_CTYPE_LSB];
		didx = 4'(reg_wdata - `LRCR_ONE);
		s_d = s_q;
		s_d.call_v = 1'b0;
		s_d.blk_v = 1'b0;
		s_d.clk_set = 1'b0;
		s_d.dopen = 4'h0;
		s_d.dclose = 4'h0;
		s_d.lon = 1'b0;
		s_d.loff = 1'b0;
		// call entry only with a decodable type
		if (wr_call && ct >= `LRCR_CTYPE_MIN && ct <= `LRCR_CTYPE_MAX)
		begin
			s_d.call = reg_wdata;
			s_d.call_v = 1'b1;
			s_d.car = ct <= LRCR_CT_CAR_HI;
		end
		// door buttons, index 0..7 maps to A open, A close, B open ...
		if (wr_door && reg_wdata <= `LRCR_DOOR_MAX)
		begin
			s_d.door = reg_wdata;
			if (reg_wdata != `LRCR_ZERO16)
			begin
				if (didx[0] == 1'b0)
					s_d.dopen[didx[2:1]] = 1'b1;
				else
					s_d.dclose[didx[2:1]] = 1'b1;
			end
		end
		// reserved bits must be clear
		if (wr_blk && (reg_wdata & `LRCR_BLK_RSVD_MASK) == `LRCR_ZERO16)
		begin
			s_d.blk = reg_wdata;
			s_d.blk_v = 1'b1;
		end
		// unlock window
		case (s_q.lock)
			LRCR_LOCKED:
			begin
				s_d.cnt = '0;
			end
			LRCR_OPEN:
			begin
				if (s_q.cnt >= RELOCK_LAST)
					s_d.lock = LRCR_LOCKED;
				else
					s_d.cnt = s_q.cnt + CNT_W'(1);
			end
			default:
			begin
				s_d.lock = LRCR_LOCKED;
			end
		endcase
		if (wr_unl && reg_wdata == `LRCR_ONE)
		begin
			s_d.lock = LRCR_OPEN;
			s_d.cnt = '0;
		end
		s_d.unl = s_d.lock == LRCR_OPEN;
		if (wr_date && s_q.lock == LRCR_OPEN)
		begin
			s_d.date = reg_wdata;
			s_d.clk_set = 1'b1;
		end
		if (wr_time && s_q.lock == LRCR_OPEN)
		begin
			s_d.tim = reg_wdata;
			s_d.clk_set = 1'b1;
		end
		// mode flags accept only 0 and 1
		if (reg_wr && reg_wdata <= `LRCR_ONE)
		begin
			if (reg_addr == `LRCR_OFS_STANDBY)
				s_d.standby = reg_wdata[0];
			if (reg_addr == `LRCR_OFS_HALL)
				s_d.hall = reg_wdata[0];
			if (reg_addr == `LRCR_OFS_HOLD)
				s_d.hold = reg_wdata[0];
			if (reg_addr == `LRCR_OFS_SERVICE)
				s_d.service = reg_wdata[0];
		end
		if (reg_wr && reg_addr == `LRCR_OFS_LIGHT && reg_wdata <= `LRCR_LIGHT_MAX)
		begin
			s_d.light = reg_wdata;
			s_d.lauto = reg_wdata == `LRCR_ZERO16;
			s_d.lon = reg_wdata == `LRCR_LIGHT_ON;
			s_d.loff = reg_wdata == `LRCR_LIGHT_OFF && doors_closed && nobody_trapped;
		end
		// read port; spare slot and unmapped read as zero
		s_d.rdata = `LRCR_ZERO16;
		if (reg_rd)
		begin
			case (reg_addr)
				`LRCR_OFS_CALL: s_d.rdata = s_q.call;
				`LRCR_OFS_UNLOCK: s_d.rdata = {15'h0, s_q.lock == LRCR_OPEN};
				`LRCR_OFS_DATE: s_d.rdata = s_q.date;
				`LRCR_OFS_TIME: s_d.rdata = s_q.tim;
				`LRCR_OFS_DOOR: s_d.rdata = s_q.door;
				`LRCR_OFS_BLOCK: s_d.rdata = s_q.blk;
				`LRCR_OFS_STANDBY: s_d.rdata = {15'h0, s_q.standby};
				`LRCR_OFS_HALL: s_d.rdata = {15'h0, s_q.hall};
				`LRCR_OFS_HOLD: s_d.rdata = {15'h0, s_q.hold};
				`LRCR_OFS_SERVICE: s_d.rdata = {15'h0, s_q.service};
				`LRCR_OFS_LIGHT: s_d.rdata = s_q.light;
				default: s_d.rdata = `LRCR_ZERO16;
			endcase
		end
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_sys or negedge rst_b)
	begin
		if (!rst_b)
			s_q <= S_RST;
		else
			s_q <= s_d;
	end

	// ==========================================
	// outputs
	assign reg_rdata = s_q.rdata;
	assign call_valid = s_q.call_v;
	assign call_floor = s_q.call[`LRCR_FLOOR_MSB:`LRCR_FLOOR_LSB];
	assign call_doors = s_q.call[`LRCR_DOORS_MSB:`LRCR_DOORS_LSB];
	assign call_type = lrcr_ctype_t'(s_q.call[`LRCR_CTYPE_MSB:`LRCR_CTYPE_LSB]);
	assign call_is_car = s_q.car;
	assign door_open_press = s_q.dopen;
	assign door_close_press = s_q.dclose;
	assign block_valid = s_q.blk_v;
	assign block_floor = s_q.blk[`LRCR_FLOOR_MSB:`LRCR_FLOOR_LSB];
	assign block_doors = s_q.blk[`LRCR_DOORS_MSB:`LRCR_DOORS_LSB];
	assign block_car_calls = s_q.blk[`LRCR_BLK_CAR_BIT];
	assign block_disable = s_q.blk[`LRCR_BLK_DIS_BIT];
	assign clock_set = s_q.clk_set;
	assign date_month = s_q.date[`LRCR_HI_MSB:`LRCR_HI_LSB];
	assign date_day = s_q.date[`LRCR_LO_MSB:`LRCR_LO_LSB];
	assign time_hour = s_q.tim[`LRCR_HI_MSB:`LRCR_HI_LSB];
	assign time_minute = s_q.tim[`LRCR_LO_MSB:`LRCR_LO_LSB];
	assign clock_unlocked = s_q.unl;
	assign standby_on = s_q.standby;
	assign hall_disabled = s_q.hall;
	assign doors_hold = s_q.hold;
	assign service_on = s_q.service;
	assign light_auto = s_q.lauto;
	assign light_on_pulse = s_q.lon;
	assign light_off_pulse = s_q.loff;

	// ==========================================
	// checks
	// clock setting and unlock window
	chk_date_locked: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_DATE && !clock_unlocked) |=> $stable(date_month) && $stable(date_day))
		else $error("date changed while locked");
	chk_time_locked: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_TIME && !clock_unlocked) |=> $stable(time_hour) && $stable(time_minute))
		else $error("time changed while locked");
	chk_unlock_grant: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_UNLOCK && reg_wdata == `LRCR_ONE) |=> clock_unlocked)
		else $error("unlock not granted");
	chk_unlock_other: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_UNLOCK && reg_wdata != `LRCR_ONE && !clock_unlocked) |=> !clock_unlocked)
		else $error("unlock granted by wrong value");
	chk_relock_fall: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$fell(clock_unlocked) |-> $past(s_q.cnt) >= RELOCK_LAST)
		else $error("relocked early");
	chk_relock_due: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(clock_unlocked && s_q.cnt >= RELOCK_LAST && !(reg_wr && reg_addr == `LRCR_OFS_UNLOCK)) |=> !clock_unlocked)
		else $error("unlock window overran");
	chk_date_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_DATE && clock_unlocked) |=> clock_set
			&& {date_month, date_day} == $past(reg_wdata))
		else $error("date not stored");
	chk_time_store: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_TIME && clock_unlocked) |=> clock_set
			&& {time_hour, time_minute} == $past(reg_wdata))
		else $error("time not stored");
	// call entry
	chk_call_type: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_CALL && reg_wdata[`LRCR_CTYPE_MSB:`LRCR_CTYPE_LSB] > `LRCR_CTYPE_MAX)
			|=> !call_valid)
		else $error("bad call type accepted");
	chk_call_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_CALL && reg_wdata[`LRCR_CTYPE_MSB:`LRCR_CTYPE_LSB] == LRCR_CT_NONE)
			|=> !call_valid)
		else $error("call of type zero accepted");
	chk_call_field: assert property (@(posedge clk_sys) disable iff (!rst_b)
		call_valid |-> {call_type, call_doors, call_floor} == $past(reg_wdata))
		else $error("call fields wrong");
	chk_call_car: assert property (@(posedge clk_sys) disable iff (!rst_b)
		call_valid |-> call_is_car == ($past(reg_wdata[`LRCR_CTYPE_MSB:`LRCR_CTYPE_LSB]) <= LRCR_CT_CAR_HI))
		else $error("car call class wrong");
	chk_call_hold: assert property (@(posedge clk_sys) disable iff (!rst_b)
		!call_valid |-> $stable({call_type, call_doors, call_floor, call_is_car}))
		else $error("call fields moved without a call");
	// door buttons
	chk_door_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_DOOR && reg_wdata == 16'h0003) |=> door_open_press == 4'h2)
		else $error("door B open not pressed");
	chk_door_close: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_DOOR && reg_wdata == 16'h0008) |=> door_close_press == 4'h8)
		else $error("door D close not pressed");
	chk_door_none: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_DOOR && reg_wdata == `LRCR_ZERO16) |=> {door_open_press, door_close_press} == 8'h00)
		else $error("door pressed on no action");
	chk_door_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_DOOR && reg_wdata > `LRCR_DOOR_MAX) |=> {door_open_press, door_close_press} == 8'h00)
		else $error("door pressed on bad value");
	chk_door_single: assert property (@(posedge clk_sys) disable iff (!rst_b)
		$onehot0({door_open_press, door_close_press}))
		else $error("more than one door button pressed");
	// call blocking
	chk_block_rsvd: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_BLOCK && (reg_wdata & `LRCR_BLK_RSVD_MASK) != `LRCR_ZERO16) |=> !block_valid)
		else $error("reserved block bit accepted");
	chk_block_fields: assert property (@(posedge clk_sys) disable iff (!rst_b)
		block_valid |-> {block_doors, block_floor} == $past(reg_wdata[`LRCR_DOORS_MSB:`LRCR_FLOOR_LSB]))
		else $error("block floor or doors wrong");
	chk_block_mode: assert property (@(posedge clk_sys) disable iff (!rst_b)
		block_valid |-> block_car_calls == $past(reg_wdata[`LRCR_BLK_CAR_BIT])
			&& block_disable == $past(reg_wdata[`LRCR_BLK_DIS_BIT]))
		else $error("block mode bits wrong");
	// mode flags
	chk_flag_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_SERVICE && reg_wdata > `LRCR_ONE) |=> $stable(service_on))
		else $error("service flag took bad value");
	chk_standby_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_STANDBY && reg_wdata <= `LRCR_ONE) |=> standby_on == $past(reg_wdata[0]))
		else $error("standby flag not taken");
	chk_hall_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_HALL && reg_wdata <= `LRCR_ONE) |=> hall_disabled == $past(reg_wdata[0]))
		else $error("landing control flag not taken");
	chk_hold_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_HOLD && reg_wdata <= `LRCR_ONE) |=> doors_hold == $past(reg_wdata[0]))
		else $error("door hold flag not taken");
	chk_service_set: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_SERVICE && reg_wdata <= `LRCR_ONE) |=> service_on == $past(reg_wdata[0]))
		else $error("service flag not taken");
	// car light override and spare slot read
	chk_light_safe: assert property (@(posedge clk_sys) disable iff (!rst_b)
		light_off_pulse |-> $past(doors_closed) && $past(nobody_trapped))
		else $error("light off while unsafe");
	chk_light_on: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_LIGHT && reg_wdata == `LRCR_LIGHT_ON) |=> light_on_pulse && !light_auto)
		else $error("light on not triggered");
	chk_light_auto: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_LIGHT && reg_wdata == `LRCR_ZERO16)
			|=> light_auto && !light_on_pulse && !light_off_pulse)
		else $error("automatic light mode not restored");
	chk_light_range: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_wr && reg_addr == `LRCR_OFS_LIGHT && reg_wdata > `LRCR_LIGHT_MAX)
			|=> !light_on_pulse && !light_off_pulse && $stable(light_auto))
		else $error("bad light value acted on");
	chk_read_spare: assert property (@(posedge clk_sys) disable iff (!rst_b)
		(reg_rd && reg_addr == `LRCR_OFS_SPARE) |=> reg_rdata == `LRCR_ZERO16)
		else $error("spare slot read not zero");
	cov_clock_set: cover property (@(posedge clk_sys) disable iff (!rst_b) clock_unlocked ##1 clock_set);
	cov_relock: cover property (@(posedge clk_sys) disable iff (!rst_b) $fell(clock_unlocked));
	cov_call: cover property (@(posedge clk_sys) disable iff (!rst_b) call_valid && !call_is_car);
	cov_light_off: cover property (@(posedge clk_sys) disable iff (!rst_b) light_off_pulse);
	cov_door_press: cover property (@(posedge clk_sys) disable iff (!rst_b) door_close_press != 4'h0);
endmodule

// ### logic/lrcr_defs.svh
// Purpose: constants for the lift remote command register bank
// Assumes: 16-bit holding registers, word addressed
// Notes: offsets are register indices
`ifndef LRCR_DEFS_SVH
`define LRCR_DEFS_SVH
// ==========================================
// register offsets
`define LRCR_OFS_SPARE 16'h9c40
`define LRCR_OFS_CALL 16'h9c41
`define LRCR_OFS_UNLOCK 16'h9c42
`define LRCR_OFS_DATE 16'h9c43
`define LRCR_OFS_TIME 16'h9c44
`define LRCR_OFS_DOOR 16'h9c45
`define LRCR_OFS_BLOCK 16'h9c46
`define LRCR_OFS_STANDBY 16'h9c47
`define LRCR_OFS_HALL 16'h9c48
`define LRCR_OFS_HOLD 16'h9c49
`define LRCR_OFS_SERVICE 16'h9c4a
`define LRCR_OFS_LIGHT 16'h9c4b
// ==========================================
// field positions
`define LRCR_FLOOR_LSB 0
`define LRCR_FLOOR_MSB 7
`define LRCR_DOORS_LSB 8
`define LRCR_DOORS_MSB 11
`define LRCR_CTYPE_LSB 12
`define LRCR_CTYPE_MSB 15
`define LRCR_BLK_CAR_BIT 12
`define LRCR_BLK_DIS_BIT 14
`define LRCR_HI_LSB 8
`define LRCR_HI_MSB 15
`define LRCR_LO_LSB 0
`define LRCR_LO_MSB 7
// ==========================================
// value limits and reset values
`define LRCR_CTYPE_MIN 4'h1
`define LRCR_CTYPE_MAX 4'hb
`define LRCR_DOOR_MAX 16'h0008
`define LRCR_LIGHT_MAX 16'h0002
`define LRCR_LIGHT_OFF 16'h0002
`define LRCR_LIGHT_ON 16'h0001
`define LRCR_ONE 16'h0001
`define LRCR_ZERO16 16'h0000
`define LRCR_BLK_RSVD_MASK 16'ha000
// ==========================================
// relock time
`define LRCR_RELOCK_MIN 10
`define LRCR_CLK_HZ 100000000
`define LRCR_RELOCK_CYC (64'd60 * `LRCR_RELOCK_MIN * `LRCR_CLK_HZ)
`endif

// ### logic/lrcr_pkg.sv
// Purpose: types for the lift remote command register bank
// Assumes: used with lrcr_defs.svh
// Notes: none
package lrcr_pkg;
	typedef enum logic [1:0]
	{
		LRCR_LOCKED = 2'h0,
		LRCR_OPEN = 2'h1
	} lrcr_lock_t;
	typedef enum logic [3:0]
	{
		LRCR_CT_NONE = 4'h0,
		LRCR_CT_CAR = 4'h1,
		LRCR_CT_CAR_LO = 4'h2,
		LRCR_CT_CAR_HI = 4'h3,
		LRCR_CT_LAND = 4'h4,
		LRCR_CT_LAND_X = 4'h5,
		LRCR_CT_LAND_LO = 4'h6,
		LRCR_CT_LAND_HI = 4'h7,
		LRCR_CT_UP = 4'h8,
		LRCR_CT_UP_X = 4'h9,
		LRCR_CT_DN = 4'ha,
		LRCR_CT_DN_X = 4'hb
	} lrcr_ctype_t;
endpackage

// ### verification/lrcr_host_model.sv
// Purpose: host model that drives the register port of the bank
// Assumes: strobes are sampled on the rising edge of clk_sys
// Notes: released address and data lines show the inverse of the last value
`timescale 1ns/1ns
`include "lrcr_defs.svh"
module lrcr_host_model
(
	input wire logic clk_sys,
	input wire logic [15:0] reg_rdata,
	output logic [15:0] reg_addr,
	output logic [15:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	// ==========================================
	// bus cycles
	initial
	begin
		reg_addr = 16'h0000;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
		#1;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		reg_addr <= ~a;
		#1;
		d = reg_rdata;
	endtask
	// unlock always goes ahead of date and time
	task automatic set_clock(input logic [15:0] dt, input logic [15:0] tm);
		wr(`LRCR_OFS_UNLOCK, 16'h0001);
		wr(`LRCR_OFS_DATE, dt);
		wr(`LRCR_OFS_TIME, tm);
	endtask
endmodule

// ### verification/lrcr_tb_top.sv
// Purpose: self-checking bench for the remote command register bank
// Assumes: short relock window set through RELOCK_CYCLES
// Notes: random fields come from a fixed seed
`timescale 1ns/1ns
`include "lrcr_defs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
module lift_remote_command_registers_tb_top;
	import lrcr_pkg::*;
	localparam longint RELOCK = 20;
	logic clk_sys, rst_b, reg_wr, reg_rd, doors_closed, nobody_trapped;
	logic [15:0] reg_addr, reg_wdata, reg_rdata, w, rdv, last_call;
	logic call_valid, call_is_car, block_valid, block_car_calls, block_disable, clock_set, clock_unlocked;
	logic standby_on, hall_disabled, doors_hold, service_on, light_auto, light_on_pulse, light_off_pulse;
	logic [7:0] call_floor, block_floor, date_month, date_day, time_hour, time_minute;
	logic [3:0] call_doors, door_open_press, door_close_press, block_doors, flags;
	lrcr_ctype_t call_type;
	int seed, errors, n_compared;
	assign flags = {standby_on, hall_disabled, doors_hold, service_on};
	lrcr_host_model u_host (.clk_sys, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);
	lrcr_bank #(.RELOCK_CYCLES(RELOCK)) u_dut (.clk_sys, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.doors_closed, .nobody_trapped, .reg_rdata, .call_valid, .call_floor, .call_doors, .call_type,
		.call_is_car, .door_open_press, .door_close_press, .block_valid, .block_floor, .block_doors,
		.block_car_calls, .block_disable, .clock_set, .date_month, .date_day, .time_hour, .time_minute,
		.clock_unlocked, .standby_on, .hall_disabled, .doors_hold, .service_on, .light_auto,
		.light_on_pulse, .light_off_pulse);
	// ==========================================
	// expectations and ending
	function automatic logic [3:0] door_exp(input int v, input int odd);
		if (v < 1 || v > 8 || (v % 2) != odd)
			return 4'h0;
		return 4'h1 << ((v - 1) / 2);
	endfunction
	task automatic stop_test();
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial
	begin
		repeat (5000) @(posedge clk_sys);
		errors++;
		stop_test();
	end
	// ==========================================
	// scenarios
	initial
	begin
		seed = 74;
		errors = 0;
		n_compared = 0;
		last_call = 16'h0000;
		rst_b = 1'b0;
		doors_closed = 1'b0;
		nobody_trapped = 1'b0;
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		#1;
		`CHK(light_auto, 1'b1)
		u_host.wr(`LRCR_OFS_DATE, 16'h0102);
		`CHK({clock_set, date_month}, 9'h000)
		u_host.wr(`LRCR_OFS_UNLOCK, 16'h0002);
		`CHK(clock_unlocked, 1'b0)
		for (int t = 0; t < 16; t++)
		begin
			w = 16'($random(seed));
			w[15:12] = t[3:0];
			u_host.wr(`LRCR_OFS_CALL, w);
			`CHK(call_valid, (t >= 1 && t <= 11))
			if (t >= 1 && t <= 11)
			begin
				`CHK({call_type, call_doors, call_floor}, w)
				`CHK(call_is_car, (t <= 3))
				last_call = w;
			end
			else
				`CHK({call_type, call_doors, call_floor}, last_call)
		end
		for (int v = 0; v < 10; v++)
		begin
			u_host.wr(`LRCR_OFS_DOOR, 16'(v));
			`CHK(door_open_press, door_exp(v, 1))
			`CHK(door_close_press, door_exp(v, 0))
		end
		for (int i = 0; i < 12; i++)
		begin
			w = 16'($random(seed));
			if (i < 3)
				w[15:13] = (i == 0) ? 3'b001 : (i == 1) ? 3'b100 : 3'b010;
			u_host.wr(`LRCR_OFS_BLOCK, w);
			`CHK(block_valid, ((w & 16'ha000) == 16'h0000))
			if ((w & 16'ha000) == 16'h0000)
				`CHK({block_disable, block_car_calls, block_doors, block_floor}, {w[14], w[12], w[11:0]})
		end
		u_host.set_clock({8'h0c, 8'h1f}, {8'h17, 8'h2a});
		`CHK({date_month, date_day}, 16'h0c1f)
		`CHK({time_hour, time_minute}, 16'h172a)
		repeat (RELOCK - 5) @(posedge clk_sys);
		#1;
		`CHK(clock_unlocked, 1'b1)
		@(posedge clk_sys);
		#1;
		`CHK(clock_unlocked, 1'b0)
		u_host.wr(`LRCR_OFS_DATE, 16'h0305);
		`CHK({clock_set, date_month}, 9'h00c)
		for (int k = 0; k < 4; k++)
		begin
			u_host.wr(`LRCR_OFS_STANDBY + 16'(k), 16'h0001);
			`CHK(flags, 4'h8 >> k)
			u_host.wr(`LRCR_OFS_STANDBY + 16'(k), 16'h0002);
			`CHK(flags, 4'h8 >> k)
			u_host.wr(`LRCR_OFS_STANDBY + 16'(k), 16'h0000);
			`CHK(flags, 4'h0)
		end
		u_host.wr(`LRCR_OFS_LIGHT, 16'h0001);
		`CHK({light_on_pulse, light_auto}, 2'b10)
		for (int c = 0; c < 4; c++)
		begin
			@(posedge clk_sys);
			{doors_closed, nobody_trapped} <= 2'(c);
			u_host.wr(`LRCR_OFS_LIGHT, 16'h0002);
			`CHK(light_off_pulse, (c == 3))
		end
		u_host.wr(`LRCR_OFS_LIGHT, 16'h0003);
		`CHK(light_off_pulse, 1'b0)
		u_host.rd(`LRCR_OFS_LIGHT, rdv);
		`CHK(rdv, 16'h0002)
		u_host.wr(`LRCR_OFS_LIGHT, 16'h0000);
		`CHK(light_auto, 1'b1)
		u_host.wr(`LRCR_OFS_SPARE, 16'hffff);
		u_host.rd(`LRCR_OFS_SPARE, rdv);
		`CHK(rdv, 16'h0000)
		u_host.rd(16'h1234, rdv);
		`CHK(rdv, 16'h0000)
		stop_test();
	end
endmodule
